// file: drive_state_status_word_tb.sv
`timescale 1ns/100ps
`default_nettype none
module drive_state_status_word_tb;
  logic clk_sys, rst_n, warn, mstart, mstop, still, cause, fb_rst, en_cmd, fr_cmd, cfg, ce;
  logic [6:0] lv;
  dss_pkg::dss_state_t st;
  wire logic en_pin, fr_pin, en_as, fr_as, rq3, rq9, rqf, blk, t15;
  wire logic [15:0] word;
  int bad_count = 0;
  int total_checks = 0;
  logic [15:0] tbl [9] = '{16'h0000, 16'h0000, 16'h0040, 16'h0021, 16'h0023, 16'h0027,
                           16'h0007, 16'h000F, 16'h0008};
  int pos [7] = '{dss_pkg::BIT_VOLT, dss_pkg::BIT_HALT, dss_pkg::BIT_REMOTE, dss_pkg::BIT_MODE_A,
                  dss_pkg::BIT_MODE_B, dss_pkg::BIT_ERR, dss_pkg::BIT_REF};

  dss_pin_model pins (.cfg_done(cfg), .en_cmd(en_cmd), .fr_cmd(fr_cmd), .enable_in(en_pin),
    .fault_reset_in(fr_pin), .enable_in_assigned(en_as), .fault_reset_in_assigned(fr_as));

  dss_status_word #(.WARN_HOLD_CYC(20)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(ce),
    .op_state(st), .dc_bus_ok(lv[0]), .warn_class0(warn), .halt_active(lv[1]),
    .remote_fieldbus(lv[2]), .mode_bit_a(lv[3]), .mode_bit_b(lv[4]), .err_stop(lv[5]),
    .mode_start(mstart), .mode_stop(mstop), .standstill(still), .zero_point_ok(lv[6]),
    .fault_cause_gone(cause), .fieldbus_fault_reset(fb_rst), .enable_in(en_pin),
    .fault_reset_in(fr_pin), .enable_in_assigned(en_as), .fault_reset_in_assigned(fr_as),
    .req_t3(rq3), .req_t9_t12(rq9), .req_fault_reset(rqf), .t3_blocked(blk), .t15_ok(t15),
    .drive_status_word(word));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // which request outputs pulsed in a fixed window, and none for two cycles
  task automatic pulses(input logic [3:0] exp, input string msg);
    logic [3:0] seen;
    logic [3:0] twice;
    seen = 4'h0;
    twice = 4'h0;
    repeat (6) begin
      @(negedge clk_sys);
      twice = twice | (seen & {t15, rqf, rq9, rq3});
      seen = {t15, rqf, rq9, rq3};
      twice = twice | (seen & ~exp);
      if (seen !== 4'h0) begin
        exp = exp & ~seen;
      end
    end
    check({12'h000, twice | exp}, 16'h0000, msg);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial begin
    #2000000;
    bad_count++;
    complete_run();
  end

  initial begin
    rst_n = 1'b0;
    {warn, mstart, mstop, still, cause, fb_rst, en_cmd, fr_cmd, cfg} = 9'h000;
    ce = 1'b1;
    lv = 7'h00;
    st = dss_pkg::dss_st_start;
    tick(4);
    check(word, 16'h0000, "reset word");
    rst_n = 1'b1;
    for (int i = 0; i < 9; i++) begin
      st = dss_pkg::dss_state_t'(i);
      tick(1);
      check(word, tbl[i] | 16'h4000, "state bits");
    end
    st = dss_pkg::dss_st_op_enabled;
    for (int i = 0; i < 7; i++) begin
      lv = 7'h01 << i;
      tick(1);
      check(word, 16'h4027 | (16'h0001 << pos[i]), "flag bit");
      check({15'h0000, blk}, {15'h0000, ~lv[0]}, "t3 block");
    end
    st = dss_pkg::dss_st_sw_disabled;
    tick(1);
    check(word, 16'hC040, "zero point kept");
    lv = 7'h00;
    st = dss_pkg::dss_st_op_enabled;
    warn = 1'b1;
    tick(1);
    warn = 1'b0;
    tick(1);
    check(word, 16'h40A7, "warn set");
    tick(19);
    check(word, 16'h40A7, "warn held");
    tick(1);
    check(word, 16'h4027, "warn expired");
    warn = 1'b1;
    tick(1);
    warn = 1'b0;
    fb_rst = 1'b1;
    tick(1);
    fb_rst = 1'b0;
    check(word, 16'h4027, "bus fault reset");
    mstart = 1'b1;
    tick(1);
    mstart = 1'b0;
    check(word, 16'h0027, "mode running");
    mstop = 1'b1;
    tick(1);
    mstop = 1'b0;
    tick(2);
    check(word, 16'h0027, "still moving");
    still = 1'b1;
    tick(2);
    check(word, 16'h4027, "standstill");
    mstart = 1'b1;
    tick(1);
    mstop = 1'b1;
    repeat (3) begin
      tick(1);
      mstop = 1'b0;
      mstart = 1'b0;
      check(word, 16'h0027, "back to back");
    end
    mstop = 1'b1;
    tick(1);
    mstop = 1'b0;
    en_cmd = 1'b1;
    pulses(4'h0, "unassigned rise");
    en_cmd = 1'b0;
    pulses(4'h0, "unassigned fall");
    cfg = 1'b1;
    tick(1);
    en_cmd = 1'b1;
    pulses(4'h1, "enable rise");
    en_cmd = 1'b0;
    pulses(4'h2, "enable fall");
    st = dss_pkg::dss_st_fault;
    cause = 1'b1;
    warn = 1'b1;
    tick(1);
    warn = 1'b0;
    fr_cmd = 1'b1;
    pulses(4'hC, "pin fault reset");
    check(word, 16'h4008, "pin reset clears warn");
    fr_cmd = 1'b0;
    cause = 1'b0;
    tick(2);
    fr_cmd = 1'b1;
    pulses(4'h4, "cause not gone");
    ce = 1'b0;
    lv = 7'h01;
    tick(2);
    check(word, 16'h4008, "frozen word");
    ce = 1'b1;
    tick(1);
    check(word, 16'h4018, "word resumes");
    complete_run();
  end
endmodule
`default_nettype wire

// file: dss_edge_det.sv
`timescale 1ns/100ps
`default_nettype none
module dss_edge_det (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // signal in, edge pulses out
  input wire logic sig_in,
  output logic rise_pulse,
  output logic fall_pulse
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else if (clk_en) begin
      sync1_reg <= sig_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign rise_pulse = clk_en && sync2_reg && !prev_reg;
  assign fall_pulse = clk_en && !sync2_reg && prev_reg;

  a_edge_single: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rise_pulse |=> !rise_pulse) else $error("rise pulse longer than one cycle");
endmodule
`default_nettype wire

// file: dss_hold_timer.sv
`timescale 1ns/100ps
`default_nettype none
module dss_hold_timer #(
  parameter int unsigned HOLD_CYC = 2_000_000
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // condition, clear and held flag
  input wire logic cond_in,
  input wire logic clear_in,
  output logic flag_out
);
  localparam int unsigned CW = $clog2(HOLD_CYC + 1);
  logic [CW-1:0] cnt_reg;
  logic flag_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (clk_en) begin
      if (clear_in) begin
        flag_reg <= 1'b0;
        cnt_reg <= '0;
      end else if (cond_in) begin
        flag_reg <= 1'b1;
        if (!flag_reg) begin
          cnt_reg <= CW'(HOLD_CYC - 1);
        end else if (cnt_reg != '0) begin
          cnt_reg <= cnt_reg - 1'b1;
        end
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
      end else begin
        flag_reg <= 1'b0;
      end
    end
  end

  assign flag_out = flag_reg;
endmodule
`default_nettype wire

// file: dss_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module dss_pin_model (
  // commands from the bench
  input wire logic cfg_done,
  input wire logic en_cmd,
  input wire logic fr_cmd,
  // signal input pins and their configuration
  output logic enable_in,
  output logic fault_reset_in,
  output logic enable_in_assigned,
  output logic fault_reset_in_assigned
);
  // functions configured before the pins are relied on
  assign enable_in_assigned = cfg_done;
  assign fault_reset_in_assigned = cfg_done;
  // pins move off the clock grid, like real field wiring
  assign #7 enable_in = en_cmd;
  assign #7 fault_reset_in = fr_cmd;
endmodule
`default_nettype wire

// file: dss_pkg.sv
`default_nettype none
package dss_pkg;
  typedef enum logic [3:0] {
    dss_st_start, dss_st_not_ready, dss_st_sw_disabled, dss_st_ready,
    dss_st_switched_on, dss_st_op_enabled, dss_st_quick_stop,
    dss_st_fault_react, dss_st_fault
  } dss_state_t;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BIT_RDY = 0;
  localparam int unsigned BIT_SWON = 1;
  localparam int unsigned BIT_OPEN = 2;
  localparam int unsigned BIT_FAULT = 3;
  localparam int unsigned BIT_VOLT = 4;
  localparam int unsigned BIT_QSTOP = 5;
  localparam int unsigned BIT_SWDIS = 6;
  localparam int unsigned BIT_WARN = 7;
  localparam int unsigned BIT_HALT = 8;
  localparam int unsigned BIT_REMOTE = 9;
  localparam int unsigned BIT_MODE_A = 10;
  localparam int unsigned BIT_RSVD = 11;
  localparam int unsigned BIT_MODE_B = 12;
  localparam int unsigned BIT_ERR = 13;
  localparam int unsigned BIT_END = 14;
  localparam int unsigned BIT_REF = 15;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned WARN_HOLD_MS = 100;
  localparam int unsigned WARN_HOLD_CYC = (CLK_HZ / 1000) * WARN_HOLD_MS;
endpackage
`default_nettype wire

// file: dss_status_word.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// - 16-bit read-only status word; bits 0-3,5,6 encode operating state.
// - not ready to switch on: bits 0,1,2,3,6 zero.
// - switch on disabled: bit 6 one, bits 0-3 zero.
// - ready/switched on/enabled: bit 5 one; bits 0,1,2 stepwise.
// - quick stop, fault reaction and fault patterns per state.
// - bit 4 shows DC bus ok; blocks transition 3 to 4 otherwise.
// - bit 7 set while class 0 warning listed; motion continues.
// - bit 7 held at least 100 ms once set.
// - fault reset clears bit 7 at once.
// - bit 8 shows halt active.
// - bit 9 shows fieldbus command control.
// - bits 10 and 12 mode specific, bit 11 reserved zero.
// - bit 13 shows an error needing cause removal.
// - bit 14 falls when operating mode starts.
// - bit 14 rises again only at standstill after end or interrupt.
// - bit 14 stays low across back-to-back modes.
// - bit 15 shows valid zero point, kept with power stage off.
// - enable input rising edge requests T3.
// - enable input falling edge requests T9 and T12.
// - fault reset input rising edge requests T15 and T16.
// - bits 4,13,14,15 exposed as voltage, error, end, ref flags.
// - T15 moves fault to switch on disabled if cause cleared.
// - T12 moves quick stop to switch on disabled, power off at once.
module dss_status_word #(
  parameter int unsigned WARN_HOLD_CYC = dss_pkg::WARN_HOLD_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // current operating state from the state machine
  input wire dss_pkg::dss_state_t op_state,
  // drive conditions
  input wire logic dc_bus_ok,
  input wire logic warn_class0,
  input wire logic halt_active,
  input wire logic remote_fieldbus,
  input wire logic mode_bit_a,
  input wire logic mode_bit_b,
  input wire logic err_stop,
  input wire logic mode_start,
  input wire logic mode_stop,
  input wire logic standstill,
  input wire logic zero_point_ok,
  input wire logic fault_cause_gone,
  input wire logic fieldbus_fault_reset,
  // signal inputs
  input wire logic enable_in,
  input wire logic fault_reset_in,
  input wire logic enable_in_assigned,
  input wire logic fault_reset_in_assigned,
  // transition requests
  output logic req_t3,
  output logic req_t9_t12,
  output logic req_fault_reset,
  output logic t3_blocked,
  output logic t15_ok,
  // status word
  output logic [15:0] drive_status_word
);
  logic en_rise;
  logic en_fall;
  logic fr_rise;
  logic any_fault_reset;
  logic warn_flag;
  logic end_reg;
  logic end_next;
  logic pending_reg;
  logic [15:0] word_next;
  logic [15:0] word_reg;

  dss_edge_det u_enable_edge (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .sig_in(enable_in),
    .rise_pulse(en_rise),
    .fall_pulse(en_fall)
  );

  dss_edge_det u_fault_reset_edge (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .sig_in(fault_reset_in),
    .rise_pulse(fr_rise),
    .fall_pulse()
  );

  // requests only from inputs that have been given their function
  assign req_t3 = en_rise && enable_in_assigned;
  assign req_t9_t12 = en_fall && enable_in_assigned;
  assign req_fault_reset = fr_rise && fault_reset_in_assigned;
  assign any_fault_reset = req_fault_reset || fieldbus_fault_reset;
  assign t3_blocked = !dc_bus_ok;
  assign t15_ok = req_fault_reset && fault_cause_gone
    && (op_state == dss_pkg::dss_st_fault);

  dss_hold_timer #(
    .HOLD_CYC(WARN_HOLD_CYC)
  ) u_warn_hold (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .cond_in(warn_class0),
    .clear_in(any_fault_reset),
    .flag_out(warn_flag)
  );

  // mode finished tracking
  always_comb begin
    end_next = end_reg;
    if (mode_start) begin
      end_next = 1'b0;
    end else if ((pending_reg || mode_stop) && standstill) begin
      end_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      end_reg <= 1'b1;
      pending_reg <= 1'b0;
    end else if (clk_en) begin
      end_reg <= end_next;
      if (mode_start) begin
        pending_reg <= 1'b0;
      end else if (mode_stop && !standstill) begin
        pending_reg <= 1'b1;
      end else if (standstill) begin
        pending_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    word_next = dss_pkg::STATUS_RESET;
    case (op_state)
      dss_pkg::dss_st_start, dss_pkg::dss_st_not_ready: begin
      end
      dss_pkg::dss_st_sw_disabled: begin
        word_next[dss_pkg::BIT_SWDIS] = 1'b1;
      end
      dss_pkg::dss_st_ready: begin
        word_next[dss_pkg::BIT_QSTOP] = 1'b1;
        word_next[dss_pkg::BIT_RDY] = 1'b1;
      end
      dss_pkg::dss_st_switched_on: begin
        word_next[dss_pkg::BIT_QSTOP] = 1'b1;
        word_next[dss_pkg::BIT_RDY] = 1'b1;
        word_next[dss_pkg::BIT_SWON] = 1'b1;
      end
      dss_pkg::dss_st_op_enabled: begin
        word_next[dss_pkg::BIT_QSTOP] = 1'b1;
        word_next[dss_pkg::BIT_RDY] = 1'b1;
        word_next[dss_pkg::BIT_SWON] = 1'b1;
        word_next[dss_pkg::BIT_OPEN] = 1'b1;
      end
      dss_pkg::dss_st_quick_stop: begin
        word_next[dss_pkg::BIT_RDY] = 1'b1;
        word_next[dss_pkg::BIT_SWON] = 1'b1;
        word_next[dss_pkg::BIT_OPEN] = 1'b1;
      end
      dss_pkg::dss_st_fault_react: begin
        word_next[dss_pkg::BIT_RDY] = 1'b1;
        word_next[dss_pkg::BIT_SWON] = 1'b1;
        word_next[dss_pkg::BIT_OPEN] = 1'b1;
        word_next[dss_pkg::BIT_FAULT] = 1'b1;
      end
      dss_pkg::dss_st_fault: begin
        word_next[dss_pkg::BIT_FAULT] = 1'b1;
      end
      default: begin
      end
    endcase
    word_next[dss_pkg::BIT_VOLT] = dc_bus_ok;
    word_next[dss_pkg::BIT_WARN] = warn_flag && !any_fault_reset;
    word_next[dss_pkg::BIT_HALT] = halt_active;
    word_next[dss_pkg::BIT_REMOTE] = remote_fieldbus;
    word_next[dss_pkg::BIT_MODE_A] = mode_bit_a;
    word_next[dss_pkg::BIT_RSVD] = 1'b0;
    word_next[dss_pkg::BIT_MODE_B] = mode_bit_b;
    word_next[dss_pkg::BIT_ERR] = err_stop;
    word_next[dss_pkg::BIT_END] = end_next;
    word_next[dss_pkg::BIT_REF] = zero_point_ok;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      word_reg <= dss_pkg::STATUS_RESET;
    end else if (clk_en) begin
      word_reg <= word_next;
    end
  end

  assign drive_status_word = word_reg;

  // warn hold counter used only by checks
  logic [31:0] warn_age_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      warn_age_reg <= '0;
    end else if (clk_en) begin
      if (!word_reg[dss_pkg::BIT_WARN]) begin
        warn_age_reg <= '0;
      end else begin
        warn_age_reg <= warn_age_reg + 32'h0000_0001;
      end
    end
  end

  // state bit patterns
  a_not_ready: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && (op_state == dss_pkg::dss_st_start || op_state == dss_pkg::dss_st_not_ready)
    |=> (drive_status_word[6:0] & 7'h4F) == 7'h00)
    else $error("not ready pattern wrong");
  a_sw_disabled: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && op_state == dss_pkg::dss_st_sw_disabled
    |=> (drive_status_word[6:0] & 7'h4F) == 7'h40)
    else $error("switch on disabled pattern wrong");
  a_ready_pattern: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && op_state == dss_pkg::dss_st_ready
    |=> (drive_status_word[6:0] & 7'h6F) == 7'h21)
    else $error("ready pattern wrong");
  a_switched_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && op_state == dss_pkg::dss_st_switched_on
    |=> (drive_status_word[6:0] & 7'h6F) == 7'h23)
    else $error("switched on pattern wrong");
  a_op_enabled: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && op_state == dss_pkg::dss_st_op_enabled
    |=> (drive_status_word[6:0] & 7'h6F) == 7'h27)
    else $error("operation enabled pattern wrong");
  a_quick_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && op_state == dss_pkg::dss_st_quick_stop
    |=> (drive_status_word[6:0] & 7'h6F) == 7'h07)
    else $error("quick stop pattern wrong");
  a_fault_react: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && op_state == dss_pkg::dss_st_fault_react
    |=> (drive_status_word[6:0] & 7'h4F) == 7'h0F)
    else $error("fault reaction pattern wrong");
  a_fault_pattern: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && op_state == dss_pkg::dss_st_fault
    |=> (drive_status_word[6:0] & 7'h4F) == 7'h08)
    else $error("fault pattern wrong");

  // condition bits
  a_volt_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en
    |=> drive_status_word[dss_pkg::BIT_VOLT] == $past(dc_bus_ok))
    else $error("voltage bit not following bus");
  a_halt_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en
    |=> drive_status_word[dss_pkg::BIT_HALT] == $past(halt_active))
    else $error("halt bit not following halt");
  a_remote_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en
    |=> drive_status_word[dss_pkg::BIT_REMOTE] == $past(remote_fieldbus))
    else $error("remote bit not following control source");
  a_mode_a_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en
    |=> drive_status_word[dss_pkg::BIT_MODE_A] == $past(mode_bit_a))
    else $error("mode bit a not following input");
  a_mode_b_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en
    |=> drive_status_word[dss_pkg::BIT_MODE_B] == $past(mode_bit_b))
    else $error("mode bit b not following input");
  a_err_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en
    |=> drive_status_word[dss_pkg::BIT_ERR] == $past(err_stop))
    else $error("error bit not following error");
  a_ref_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en
    |=> drive_status_word[dss_pkg::BIT_REF] == $past(zero_point_ok))
    else $error("zero point bit not following input");
  a_reserved: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !drive_status_word[dss_pkg::BIT_RSVD])
    else $error("reserved bit set");

  // warning and mode end
  a_warn_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && warn_class0 && !any_fault_reset ##1 clk_en && !any_fault_reset
    |=> drive_status_word[dss_pkg::BIT_WARN])
    else $error("warning bit not set");
  a_warn_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(drive_status_word[dss_pkg::BIT_WARN])
    |-> $past(any_fault_reset) || $past(warn_age_reg) >= WARN_HOLD_CYC - 1)
    else $error("warning bit dropped too early");
  a_warn_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && any_fault_reset
    |=> !drive_status_word[dss_pkg::BIT_WARN])
    else $error("fault reset did not clear warning");
  a_end_falls: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && mode_start
    |=> !drive_status_word[dss_pkg::BIT_END])
    else $error("end bit not cleared at mode start");
  a_end_waits: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && !end_reg && !standstill
    |=> !drive_status_word[dss_pkg::BIT_END])
    else $error("end bit set before standstill");
  a_end_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && mode_stop && standstill && !mode_start
    |=> drive_status_word[dss_pkg::BIT_END])
    else $error("end bit not set at standstill");

  // transition requests and clock enable
  a_enable_req: assert property (@(posedge clk_sys) disable iff (!rst_n)
    req_t3
    |-> !req_t9_t12 ##1 !req_t3)
    else $error("enable request malformed");
  a_disable_req: assert property (@(posedge clk_sys) disable iff (!rst_n)
    req_t9_t12
    |-> !req_t3 ##1 !req_t9_t12)
    else $error("disable request malformed");
  a_fault_req: assert property (@(posedge clk_sys) disable iff (!rst_n)
    req_fault_reset
    |=> !req_fault_reset)
    else $error("fault reset request longer than one cycle");
  a_enable_gated: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !enable_in_assigned
    |-> !req_t3 && !req_t9_t12)
    else $error("enable request from unassigned input");
  a_reset_gated: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !fault_reset_in_assigned
    |-> !req_fault_reset && !t15_ok)
    else $error("fault reset request from unassigned input");
  a_t15_state: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_state != dss_pkg::dss_st_fault || !fault_cause_gone
    |-> !t15_ok)
    else $error("fault clear outside fault state");
  a_word_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !clk_en
    |=> $stable(drive_status_word))
    else $error("status word moved while disabled");
  a_req_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !clk_en
    |-> !req_t3 && !req_t9_t12 && !req_fault_reset)
    else $error("request while clock enable low");

  c_warn_set: cover property (@(posedge clk_sys) $rose(drive_status_word[dss_pkg::BIT_WARN]));
  c_enable: cover property (@(posedge clk_sys) req_t3);
  c_disable: cover property (@(posedge clk_sys) req_t9_t12);
  c_fault_reset: cover property (@(posedge clk_sys) t15_ok);
  c_mode_end: cover property (@(posedge clk_sys) $rose(drive_status_word[dss_pkg::BIT_END]));
endmodule
`default_nettype wire
